// File: design/security_config_registers.sv
// Behaviour
// - Upper gray input holds ten bits, rest reserved
// - Convert 42-bit gray; low 32 bits readable
// - Binary bits 41..32 in upper output register
// - Bulk erase block bit sticks until reset
// - Four info sector blocks stick until reset
// - Erase inhibit writable only with key index 3
// - Read protect word accepts one write per reset
// - Exec lock bit freezes both exec registers
// - Six bank execute permission bits
// - Exec copy writable only with key index 2
// - Lifecycle code readable in both registers
// - Debug registers writable only when gate 1010b
// - Passive debug: 10b enables, 01b disables
// - Halting debug: 10b enables, 01b disables
// - Debug permission cleared only by power-on reset
// - Debug copy needs key index 1, key reset
// - Unlock code enables port; reads 0xA else 0x5
// - Port unlock written once, power-on reset only
// - Beacon loaded once by boot, then read-only
// - Chip identifier readable, writes ignored
module security_config_registers
    import sec_cfg_pkg::*;
#(
    parameter logic [31:0] CHIP_IDENT = 32'h0000_1001, // Arbitrary neutral value
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] gray_in_low_i,
    input wire logic [7:0] key_write_index_i,
    input wire logic key_unlock_reset_i,
    input wire logic [LIFECYCLE_W-1:0] lifecycle_code_i,
    input wire logic [31:0] part_variant_info_i,
    output logic bulk_erase_block_o,
    output logic [INFO_SECTORS-1:0] info_sector_erase_block_o,
    output logic [31:0] read_protect_word_o,
    output logic [EXEC_BANKS-1:0] exec_permit_o,
    output logic [EXEC_BANKS-1:0] exec_permit_copy_o,
    output logic exec_lock_o,
    output logic cpu_passive_dbg_enable_o,
    output logic cpu_halting_dbg_enable_o,
    output logic cpu_passive_dbg_enable_copy_o,
    output logic cpu_halting_dbg_enable_copy_o,
    output logic cpu_dbg_port_enable_o,
    output logic [31:0] auth_marker_o
);

    // ----------
    // Elaboration checks
    // ----------
    if (ADDR_W != 12) begin : g_bad_addr
        $error("ADDR_W must be 12 for this register map");
    end

    // ----------
    // Bus slave
    // ----------
    logic ack_r;
    logic req;
    logic wr_en;
    logic [31:0] lane_mask;
    logic [31:0] rd_nxt;
    logic [31:0] rd_r;

    assign req = wb_cyc_i && wb_stb_i;
    // Writes commit on the edge where the master samples ack
    assign wr_en = req && wb_we_i && ack_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    logic hit_gray_high;
    logic hit_flash;
    logic hit_rop;
    logic hit_exec;
    logic hit_exec_copy;
    logic hit_gate;
    logic hit_dbg;
    logic hit_dbg_copy;
    logic hit_port;
    logic hit_marker;

    assign hit_gray_high = wr_en && (wb_adr_i == OFS_GRAY_IN_HIGH);
    assign hit_flash = wr_en && (wb_adr_i == OFS_FLASH_ERASE_INHIBIT);
    assign hit_rop = wr_en && (wb_adr_i == OFS_READ_PROTECT_LEVEL);
    assign hit_exec = wr_en && (wb_adr_i == OFS_SRAM_EXEC_PERMIT);
    assign hit_exec_copy = wr_en && (wb_adr_i == OFS_SRAM_EXEC_PERMIT_COPY);
    assign hit_gate = wr_en && (wb_adr_i == OFS_DBG_WRITE_GATE);
    assign hit_dbg = wr_en && (wb_adr_i == OFS_DBG_PERMISSION_CTRL);
    assign hit_dbg_copy = wr_en && (wb_adr_i == OFS_DBG_PERMISSION_CTRL_COPY);
    assign hit_port = wr_en && (wb_adr_i == OFS_CPU_DBG_PORT_UNLOCK);
    assign hit_marker = wr_en && (wb_adr_i == OFS_AUTH_MARKER_WORD);

    // ----------
    // Gray to binary converter
    // ----------
    logic [GRAY_HIGH_W-1:0] gray_high_r;
    logic [GRAY_W-1:0] gray_full;
    logic [GRAY_W-1:0] bin_nxt;
    logic [GRAY_W-1:0] bin_r;
    logic [31:0] gray_high_wr;

    assign gray_high_wr = merge({22'h000000, gray_high_r}, wb_dat_i, lane_mask);

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            gray_high_r <= '0;
        end else if (hit_gray_high) begin
            gray_high_r <= gray_high_wr[GRAY_HIGH_W-1:0];
        end
    end

    assign gray_full = {gray_high_r, gray_in_low_i};

    // Each binary bit is the parity of all gray bits at and above it
    for (genvar i = 0; i < GRAY_W; i++) begin : g_gray
        assign bin_nxt[i] = ^gray_full[GRAY_W-1:i];
    end

    // One register stage keeps the 42-deep parity chain off the read path
    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            bin_r <= '0;
        end else begin
            bin_r <= bin_nxt;
        end
    end

    // ----------
    // Flash erase inhibit
    // ----------
    logic bulk_erase_block_r;
    logic [INFO_SECTORS-1:0] info_block_r;
    logic [31:0] flash_wr;

    assign flash_wr = wb_dat_i & lane_mask;

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            bulk_erase_block_r <= 1'b0;
            info_block_r <= '0;
        end else if (hit_flash && key_write_index_i == KEY_INDEX_FLASH_ERASE) begin
            bulk_erase_block_r <= bulk_erase_block_r | flash_wr[BULK_ERASE_POS];
            info_block_r <= info_block_r | flash_wr[INFO_SECTORS-1:0];
        end
    end

    // ----------
    // Read protect word
    // ----------
    logic [31:0] rop_r;
    logic rop_written_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            rop_r <= WORD_ZERO;
            rop_written_r <= 1'b0;
        end else if (hit_rop && !rop_written_r) begin
            rop_r <= merge(rop_r, wb_dat_i, lane_mask);
            rop_written_r <= 1'b1;
        end
    end

    // ----------
    // SRAM execute permission
    // ----------
    logic exec_lock_r;
    logic [EXEC_BANKS-1:0] exec_r;
    logic [EXEC_BANKS-1:0] exec_copy_r;
    logic [31:0] exec_wr;
    logic [31:0] exec_copy_wr;

    assign exec_wr = merge({exec_lock_r, 25'h0000000, exec_r}, wb_dat_i, lane_mask);
    assign exec_copy_wr = merge({26'h0000000, exec_copy_r}, wb_dat_i, lane_mask);

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            exec_lock_r <= 1'b0;
            exec_r <= '0;
        end else if (hit_exec && !exec_lock_r) begin
            exec_lock_r <= exec_wr[EXEC_LOCK_POS];
            exec_r <= exec_wr[EXEC_BANKS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            exec_copy_r <= '0;
        end else if (hit_exec_copy && !exec_lock_r
                     && key_write_index_i == KEY_INDEX_EXEC_COPY) begin
            exec_copy_r <= exec_copy_wr[EXEC_BANKS-1:0];
        end
    end

    // ----------
    // Debug write gate
    // ----------
    logic [GATE_W-1:0] gate_r;
    logic [31:0] gate_wr;
    logic gate_open;

    assign gate_wr = merge({28'h0000000, gate_r}, wb_dat_i, lane_mask);
    assign gate_open = (gate_r == GATE_OPEN_CODE);

    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            gate_r <= GATE_RESET;
        end else if (hit_gate) begin
            gate_r <= gate_wr[GATE_W-1:0];
        end
    end

    // ----------
    // Debug permission control and its copy
    // ----------
    logic [3:0] dbg_r;
    logic [3:0] dbg_copy_r;
    logic [31:0] dbg_wr;
    logic [31:0] dbg_copy_wr;

    assign dbg_wr = merge({28'h0000000, dbg_r}, wb_dat_i, lane_mask);
    assign dbg_copy_wr = merge({28'h0000000, dbg_copy_r}, wb_dat_i, lane_mask);

    // System reset deliberately absent: only power-on clears it
    always_ff @(posedge clk_i) begin
        if (por_rst_i) begin
            dbg_r <= DBG_PERMISSION_RESET;
        end else if (hit_dbg && gate_open) begin
            dbg_r <= dbg_wr[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_rst_i || key_unlock_reset_i) begin
            dbg_copy_r <= DBG_PERMISSION_RESET;
        end else if (hit_dbg_copy && gate_open && key_write_index_i == KEY_INDEX_DBG_COPY) begin
            dbg_copy_r <= dbg_copy_wr[3:0];
        end
    end

    // Reserved codes leave the feature off
    assign cpu_passive_dbg_enable_o = (dbg_r[PASSIVE_DBG_POS +: 2] == DBG_CODE_ENABLE);
    assign cpu_halting_dbg_enable_o = (dbg_r[HALTING_DBG_POS +: 2] == DBG_CODE_ENABLE);
    assign cpu_passive_dbg_enable_copy_o = (dbg_copy_r[PASSIVE_DBG_POS +: 2] == DBG_CODE_ENABLE);
    assign cpu_halting_dbg_enable_copy_o = (dbg_copy_r[HALTING_DBG_POS +: 2] == DBG_CODE_ENABLE);

    // ----------
    // Debug port unlock
    // ----------
    logic port_written_r;
    logic port_enable_r;
    logic [31:0] port_wr;

    assign port_wr = wb_dat_i & lane_mask;

    always_ff @(posedge clk_i) begin
        if (por_rst_i) begin
            port_written_r <= 1'b0;
            port_enable_r <= 1'b0;
        end else if (hit_port && gate_open && !port_written_r) begin
            port_written_r <= 1'b1;
            port_enable_r <= (port_wr == PORT_UNLOCK_CODE);
        end
    end

    // ----------
    // Authentication marker word
    // ----------
    logic [31:0] marker_r;
    logic marker_loaded_r;

    always_ff @(posedge clk_i) begin
        if (por_rst_i) begin
            marker_r <= WORD_ZERO;
            marker_loaded_r <= 1'b0;
        end else if (hit_marker && gate_open && !marker_loaded_r) begin
            marker_r <= merge(marker_r, wb_dat_i, lane_mask);
            marker_loaded_r <= 1'b1;
        end
    end

    // ----------
    // Read multiplexer
    // ----------
    always_comb begin
        rd_nxt = WORD_ZERO;
        unique case (wb_adr_i)
            OFS_GRAY_IN_HIGH: begin
                rd_nxt[GRAY_HIGH_W-1:0] = gray_high_r;
            end
            OFS_BIN_OUT_LOW: begin
                rd_nxt = bin_r[31:0];
            end
            OFS_BIN_OUT_HIGH: begin
                rd_nxt[GRAY_HIGH_W-1:0] = bin_r[GRAY_W-1:32];
            end
            OFS_FLASH_ERASE_INHIBIT: begin
                rd_nxt[BULK_ERASE_POS] = bulk_erase_block_r;
                rd_nxt[INFO_SECTORS-1:0] = info_block_r;
            end
            OFS_READ_PROTECT_LEVEL: begin
                rd_nxt = rop_r;
            end
            OFS_SRAM_EXEC_PERMIT: begin
                rd_nxt[EXEC_LOCK_POS] = exec_lock_r;
                rd_nxt[EXEC_BANKS-1:0] = exec_r;
            end
            OFS_SRAM_EXEC_PERMIT_COPY: begin
                rd_nxt[EXEC_BANKS-1:0] = exec_copy_r;
            end
            OFS_LIFECYCLE_STATE, OFS_LIFECYCLE_STATE_COPY: begin
                rd_nxt[LIFECYCLE_W-1:0] = lifecycle_code_i;
            end
            OFS_DBG_WRITE_GATE: begin
                rd_nxt[GATE_W-1:0] = gate_r;
            end
            OFS_DBG_PERMISSION_CTRL: begin
                rd_nxt[3:0] = dbg_r;
            end
            OFS_DBG_PERMISSION_CTRL_COPY: begin
                rd_nxt[3:0] = dbg_copy_r;
            end
            OFS_CPU_DBG_PORT_UNLOCK: begin
                rd_nxt = port_enable_r ? PORT_READ_ENABLED : PORT_READ_DENIED;
            end
            OFS_AUTH_MARKER_WORD: begin
                rd_nxt = marker_r;
            end
            OFS_TEST_PORT_CHIP_IDENT: begin
                rd_nxt = CHIP_IDENT;
            end
            OFS_PART_VARIANT_INFO: begin
                rd_nxt = part_variant_info_i;
            end
            default: begin
                rd_nxt = WORD_ZERO;
            end
        endcase
    end

    // Data is captured with the rising ack, so it stands while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            rd_r <= WORD_ZERO;
        end else if (req && !ack_r) begin
            rd_r <= rd_nxt;
        end
    end

    // ----------
    // Outputs
    // ----------
    assign bulk_erase_block_o = bulk_erase_block_r;
    assign info_sector_erase_block_o = info_block_r;
    assign read_protect_word_o = rop_r;
    assign exec_permit_o = exec_r;
    assign exec_permit_copy_o = exec_copy_r;
    assign exec_lock_o = exec_lock_r;
    assign cpu_dbg_port_enable_o = port_enable_r;
    assign auth_marker_o = marker_r;

endmodule

// File: include/sec_cfg_pkg.sv
package sec_cfg_pkg;

    // ----------
    // Register byte offsets
    // ----------
    localparam logic [11:0] OFS_GRAY_IN_HIGH = 12'hb64;
    localparam logic [11:0] OFS_BIN_OUT_LOW = 12'hb68;
    localparam logic [11:0] OFS_BIN_OUT_HIGH = 12'hb6c;
    localparam logic [11:0] OFS_FLASH_ERASE_INHIBIT = 12'he1c;
    localparam logic [11:0] OFS_READ_PROTECT_LEVEL = 12'he3c;
    localparam logic [11:0] OFS_SRAM_EXEC_PERMIT = 12'he58;
    localparam logic [11:0] OFS_SRAM_EXEC_PERMIT_COPY = 12'he5c;
    localparam logic [11:0] OFS_LIFECYCLE_STATE = 12'he80;
    localparam logic [11:0] OFS_LIFECYCLE_STATE_COPY = 12'he84;
    localparam logic [11:0] OFS_DBG_WRITE_GATE = 12'hfa0;
    localparam logic [11:0] OFS_DBG_PERMISSION_CTRL = 12'hfa4;
    localparam logic [11:0] OFS_DBG_PERMISSION_CTRL_COPY = 12'hfa8;
    localparam logic [11:0] OFS_CPU_DBG_PORT_UNLOCK = 12'hfb4;
    localparam logic [11:0] OFS_AUTH_MARKER_WORD = 12'hfc0;
    localparam logic [11:0] OFS_TEST_PORT_CHIP_IDENT = 12'hff0;
    localparam logic [11:0] OFS_PART_VARIANT_INFO = 12'hff4;

    // ----------
    // Field positions and widths
    // ----------
    localparam int GRAY_W = 42;
    localparam int GRAY_HIGH_W = 10;
    localparam int BULK_ERASE_POS = 8;
    localparam int INFO_SECTORS = 4;
    localparam int EXEC_BANKS = 6;
    localparam int EXEC_LOCK_POS = 31;
    localparam int LIFECYCLE_W = 8;
    localparam int GATE_W = 4;
    localparam int PASSIVE_DBG_POS = 2;
    localparam int HALTING_DBG_POS = 0;

    // ----------
    // Codes and reset values
    // ----------
    localparam logic [3:0] GATE_OPEN_CODE = 4'ha;
    localparam logic [3:0] GATE_RESET = 4'ha;
    localparam logic [1:0] DBG_CODE_ENABLE = 2'h2;
    localparam logic [1:0] DBG_CODE_DISABLE = 2'h1;
    localparam logic [3:0] DBG_PERMISSION_RESET = 4'h5;
    localparam logic [31:0] PORT_UNLOCK_CODE = 32'h12345678;
    localparam logic [31:0] PORT_READ_ENABLED = 32'h0000000a;
    localparam logic [31:0] PORT_READ_DENIED = 32'h00000005;
    localparam logic [7:0] KEY_INDEX_FLASH_ERASE = 8'h03;
    localparam logic [7:0] KEY_INDEX_EXEC_COPY = 8'h02;
    localparam logic [7:0] KEY_INDEX_DBG_COPY = 8'h01;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

endpackage

// File: verification/sec_cfg_chk.sv
module sec_cfg_chk
    import sec_cfg_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [7:0] key_write_index_i,
    input wire logic bulk_erase_block_o,
    input wire logic [INFO_SECTORS-1:0] info_sector_erase_block_o,
    input wire logic [31:0] read_protect_word_o,
    input wire logic [EXEC_BANKS-1:0] exec_permit_o,
    input wire logic [EXEC_BANKS-1:0] exec_permit_copy_o,
    input wire logic exec_lock_o,
    input wire logic cpu_passive_dbg_enable_o,
    input wire logic cpu_halting_dbg_enable_o,
    input wire logic cpu_dbg_port_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_ack;
    logic rop_done_r;
    assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    // Lags the commit edge, so the first write is not judged
    always_ff @(posedge clk_i) begin
        if (rst_i || por_rst_i) begin
            rop_done_r <= 1'b0;
        end else if (wr_ack && wb_adr_i == OFS_READ_PROTECT_LEVEL) begin
            rop_done_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || por_rst_i);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack did not follow request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_erase_bits_stick: assert property (1 |=>
        ((info_sector_erase_block_o & $past(info_sector_erase_block_o)) == $past(info_sector_erase_block_o))
        && (bulk_erase_block_o || !$past(bulk_erase_block_o)))
        else $error("erase block bit cleared");
    a_erase_needs_key: assert property ($rose(bulk_erase_block_o) || (info_sector_erase_block_o &
        ~$past(info_sector_erase_block_o)) != 4'h0 |-> $past(wr_ack && wb_adr_i == OFS_FLASH_ERASE_INHIBIT
        && key_write_index_i == KEY_INDEX_FLASH_ERASE))
        else $error("erase bit set without key");
    a_rop_one_write: assert property (rop_done_r |=> $stable(read_protect_word_o))
        else $error("read protect word changed twice");
    a_exec_lock_freezes: assert property (exec_lock_o |=> exec_lock_o && $stable(exec_permit_o) &&
        $stable(exec_permit_copy_o))
        else $error("locked exec registers changed");
    a_exec_copy_keyed: assert property ($changed(exec_permit_copy_o) |-> $past(rst_i || por_rst_i) ||
        $past(wr_ack && wb_adr_i == OFS_SRAM_EXEC_PERMIT_COPY && key_write_index_i == KEY_INDEX_EXEC_COPY
        && !exec_lock_o))
        else $error("exec copy changed without key");
    a_dbg_por_only: assert property (disable iff (por_rst_i) $changed(cpu_passive_dbg_enable_o) ||
        $changed(cpu_halting_dbg_enable_o) |-> $past(por_rst_i) || $past(wr_ack && wb_adr_i ==
        OFS_DBG_PERMISSION_CTRL))
        else $error("debug enables changed without write");
    a_port_keeps: assert property (disable iff (por_rst_i)
        cpu_dbg_port_enable_o |=> cpu_dbg_port_enable_o)
        else $error("port enable dropped");
    a_port_code: assert property ($rose(cpu_dbg_port_enable_o) |-> $past(wr_ack && wb_adr_i ==
        OFS_CPU_DBG_PORT_UNLOCK && wb_dat_i == PORT_UNLOCK_CODE))
        else $error("port enabled without code");
endmodule

bind security_config_registers sec_cfg_chk #(.ADDR_W(ADDR_W)) u_sec_cfg_chk (.clk_i, .rst_i, .por_rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .key_write_index_i, .bulk_erase_block_o,
    .info_sector_erase_block_o, .read_protect_word_o, .exec_permit_o, .exec_permit_copy_o, .exec_lock_o,
    .cpu_passive_dbg_enable_o, .cpu_halting_dbg_enable_o, .cpu_dbg_port_enable_o);

// File: verification/tb_security_config_registers.sv
module tb_security_config_registers
    import sec_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = 32'h0000_2a17; // Arbitrary test value
    int seed = 32'hc725;
    int n_errors = 0;
    int total_checks = 0;
    logic clk_i = 1'b0, rst_i = 1'b1, por_rst_i = 1'b1, key_unlock_reset_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [11:0] wb_adr_i = 12'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, read_protect_word_o, auth_marker_o;
    logic [31:0] gray_in_low_i = 32'h0, part_variant_info_i = 32'h0;
    logic [7:0] key_write_index_i = 8'h0, lifecycle_code_i = 8'h0;
    logic bulk_erase_block_o, exec_lock_o, cpu_dbg_port_enable_o;
    logic cpu_passive_dbg_enable_o, cpu_halting_dbg_enable_o;
    logic cpu_passive_dbg_enable_copy_o, cpu_halting_dbg_enable_copy_o;
    logic [3:0] info_sector_erase_block_o;
    logic [5:0] exec_permit_o, exec_permit_copy_o;

    security_config_registers #(.CHIP_IDENT(IDENT), .ADDR_W(12)) u_security_config_registers (.clk_i, .rst_i,
        .por_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .gray_in_low_i, .key_write_index_i, .key_unlock_reset_i, .lifecycle_code_i, .part_variant_info_i,
        .bulk_erase_block_o, .info_sector_erase_block_o, .read_protect_word_o, .exec_permit_o,
        .exec_permit_copy_o, .exec_lock_o, .cpu_passive_dbg_enable_o, .cpu_halting_dbg_enable_o,
        .cpu_passive_dbg_enable_copy_o, .cpu_halting_dbg_enable_copy_o, .cpu_dbg_port_enable_o, .auth_marker_o);

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ----------
    // Bus and checking helpers
    // ----------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ack is read before this edge's updates land
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 16) begin
            n_errors++;
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(name, exp, q);
    endtask

    task automatic pulse(input bit por);
        @(posedge clk_i);
        if (por) begin
            por_rst_i <= 1'b1;
        end else begin
            rst_i <= 1'b1;
        end
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_rst_i <= 1'b0;
    endtask

    function automatic logic [41:0] g2b(input logic [41:0] g);
        logic [41:0] b;
        b[41] = g[41];
        for (int i = 40; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [31:0] dec(input logic [3:0] c, input logic [3:0] cc);
        return {28'h0, c[3:2] == DBG_CODE_ENABLE, c[1:0] == DBG_CODE_ENABLE, cc[3:2] == DBG_CODE_ENABLE,
            cc[1:0] == DBG_CODE_ENABLE};
    endfunction

    // ----------
    // Main sequence
    // ----------
    initial begin
        logic [41:0] g;
        logic [41:0] b;
        logic [31:0] r1;
        static logic [3:0] codes [4] = '{4'h5, 4'ha, 4'h9, 4'h6};
        lifecycle_code_i <= $random(seed);
        part_variant_info_i <= $random(seed);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        por_rst_i <= 1'b0;
        rd_chk("port_init", OFS_CPU_DBG_PORT_UNLOCK, PORT_READ_DENIED);
        wr(OFS_TEST_PORT_CHIP_IDENT, ~IDENT);
        rd_chk("ident", OFS_TEST_PORT_CHIP_IDENT, IDENT);
        rd_chk("lc", OFS_LIFECYCLE_STATE, {24'h0, lifecycle_code_i});
        rd_chk("lc_copy", OFS_LIFECYCLE_STATE_COPY, {24'h0, lifecycle_code_i});
        rd_chk("unmapped", 12'h004, 32'h0);
        for (int k = 0; k < 8; k++) begin
            g = (k == 0) ? {42{1'b1}} : {$random(seed), $random(seed)};
            b = g2b(g);
            gray_in_low_i <= g[31:0];
            r1 = $random(seed);
            r1[9:0] = g[41:32];
            wr(OFS_GRAY_IN_HIGH, r1);
            rd_chk("gray_high", OFS_GRAY_IN_HIGH, {22'h0, g[41:32]});
            rd_chk("bin_low", OFS_BIN_OUT_LOW, b[31:0]);
            rd_chk("bin_high", OFS_BIN_OUT_HIGH, {22'h0, b[41:32]});
        end
        wr(OFS_BIN_OUT_HIGH, 32'hffffffff);
        rd_chk("bin_high_ro", OFS_BIN_OUT_HIGH, {22'h0, b[41:32]});
        key_write_index_i <= KEY_INDEX_EXEC_COPY;
        wr(OFS_FLASH_ERASE_INHIBIT, 32'h10f);
        rd_chk("erase_nokey", OFS_FLASH_ERASE_INHIBIT, 32'h0);
        key_write_index_i <= KEY_INDEX_FLASH_ERASE;
        wr(OFS_FLASH_ERASE_INHIBIT, 32'h102);
        wr(OFS_FLASH_ERASE_INHIBIT, 32'h0);
        rd_chk("erase_sticky", OFS_FLASH_ERASE_INHIBIT, 32'h102);
        wr(OFS_FLASH_ERASE_INHIBIT, 32'hffffffff);
        rd_chk("erase_all", OFS_FLASH_ERASE_INHIBIT, 32'h10f);
        check("erase_pins", 32'h1f, {27'h0, bulk_erase_block_o, info_sector_erase_block_o});
        r1 = $random(seed);
        wr(OFS_READ_PROTECT_LEVEL, r1);
        wr(OFS_READ_PROTECT_LEVEL, ~r1);
        rd_chk("rop_once", OFS_READ_PROTECT_LEVEL, r1);
        check("rop_pin", r1, read_protect_word_o);
        pulse(1'b0);
        rd_chk("erase_reset", OFS_FLASH_ERASE_INHIBIT, 32'h0);
        wr(OFS_READ_PROTECT_LEVEL, ~r1);
        rd_chk("rop_rearm", OFS_READ_PROTECT_LEVEL, ~r1);
        key_write_index_i <= KEY_INDEX_DBG_COPY;
        wr(OFS_SRAM_EXEC_PERMIT_COPY, 32'h3f);
        rd_chk("xcopy_nokey", OFS_SRAM_EXEC_PERMIT_COPY, 32'h0);
        key_write_index_i <= KEY_INDEX_EXEC_COPY;
        wr(OFS_SRAM_EXEC_PERMIT_COPY, 32'h7fffff15);
        rd_chk("xcopy", OFS_SRAM_EXEC_PERMIT_COPY, 32'h15);
        wr(OFS_SRAM_EXEC_PERMIT, 32'h2a);
        rd_chk("xen", OFS_SRAM_EXEC_PERMIT, 32'h2a);
        check("xen_pins", 32'ha95, {20'h0, exec_permit_o, exec_permit_copy_o});
        wr(OFS_SRAM_EXEC_PERMIT, 32'h80000011);
        wr(OFS_SRAM_EXEC_PERMIT, 32'h0);
        wr(OFS_SRAM_EXEC_PERMIT_COPY, 32'h0);
        rd_chk("xen_locked", OFS_SRAM_EXEC_PERMIT, 32'h80000011);
        rd_chk("xcopy_locked", OFS_SRAM_EXEC_PERMIT_COPY, 32'h15);
        check("lock_pin", 32'h1, {31'h0, exec_lock_o});
        key_write_index_i <= KEY_INDEX_DBG_COPY;
        foreach (codes[i]) begin
            r1 = $random(seed);
            wr(OFS_DBG_PERMISSION_CTRL, {r1[31:4], codes[i]});
            wr(OFS_DBG_PERMISSION_CTRL_COPY, {28'h0, ~codes[i]});
            rd_chk("dbg", OFS_DBG_PERMISSION_CTRL, {28'h0, codes[i]});
            check("dbg_pins", dec(codes[i], ~codes[i]), {28'h0, cpu_passive_dbg_enable_o,
                cpu_halting_dbg_enable_o, cpu_passive_dbg_enable_copy_o, cpu_halting_dbg_enable_copy_o});
        end
        key_unlock_reset_i <= 1'b1;
        @(posedge clk_i);
        key_unlock_reset_i <= 1'b0;
        key_write_index_i <= 8'h0;
        wr(OFS_DBG_PERMISSION_CTRL_COPY, 32'ha);
        rd_chk("dbg_copy_keyreset", OFS_DBG_PERMISSION_CTRL_COPY, {28'h0, DBG_PERMISSION_RESET});
        pulse(1'b0);
        rd_chk("dbg_keep", OFS_DBG_PERMISSION_CTRL, 32'h6);
        wr(OFS_DBG_WRITE_GATE, 32'hfffffff5);
        rd_chk("gate", OFS_DBG_WRITE_GATE, 32'h5);
        wr(OFS_DBG_PERMISSION_CTRL, 32'h9);
        wr(OFS_CPU_DBG_PORT_UNLOCK, PORT_UNLOCK_CODE);
        wr(OFS_AUTH_MARKER_WORD, r1);
        rd_chk("dbg_shut", OFS_DBG_PERMISSION_CTRL, 32'h6);
        rd_chk("port_shut", OFS_CPU_DBG_PORT_UNLOCK, PORT_READ_DENIED);
        rd_chk("marker_shut", OFS_AUTH_MARKER_WORD, 32'h0);
        wr(OFS_DBG_WRITE_GATE, {28'h0, GATE_OPEN_CODE});
        wr(OFS_AUTH_MARKER_WORD, r1);
        wr(OFS_AUTH_MARKER_WORD, ~r1);
        rd_chk("marker", OFS_AUTH_MARKER_WORD, r1);
        check("marker_pin", r1, auth_marker_o);
        wr(OFS_CPU_DBG_PORT_UNLOCK, PORT_UNLOCK_CODE);
        wr(OFS_CPU_DBG_PORT_UNLOCK, 32'h0);
        pulse(1'b0);
        rd_chk("port_open", OFS_CPU_DBG_PORT_UNLOCK, PORT_READ_ENABLED);
        check("port_pin", 32'h1, {31'h0, cpu_dbg_port_enable_o});
        pulse(1'b1);
        rd_chk("dbg_por", OFS_DBG_PERMISSION_CTRL, {28'h0, DBG_PERMISSION_RESET});
        rd_chk("port_por", OFS_CPU_DBG_PORT_UNLOCK, PORT_READ_DENIED);
        rd_chk("marker_por", OFS_AUTH_MARKER_WORD, 32'h0);
        finish_test();
    end
endmodule
